// ---- psd_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module psd_board_model (
  // strap pattern
  input  wire logic [4:0] pattern_i,
  // strap levels
  output logic            bp_o,
  output logic            pause_o,
  output logic            manual_o,
  output logic            hb_o,
  output logic            pol_o
);
  // ------------
  // fixed resistor levels, steady from reset on
  // ------------
  assign bp_o     = pattern_i[0];
  assign pause_o  = pattern_i[1];
  assign manual_o = pattern_i[2];
  assign hb_o     = pattern_i[3];
  assign pol_o    = pattern_i[4];
endmodule // psd_board_model
`default_nettype wire

// ---- psd_pkg.sv ----
package psd_pkg;
  // ----------------------------------------
  // synchroniser lane positions
  // ----------------------------------------
  localparam int unsigned SYNC_W          = 6;
  localparam int unsigned LN_DUPLEX_PIN   = 0;
  localparam int unsigned LN_DUPLEX_POL   = 1;
  localparam int unsigned LN_BP_STRAP     = 2;
  localparam int unsigned LN_PAUSE_STRAP  = 3;
  localparam int unsigned LN_MANUAL_STRAP = 4;
  localparam int unsigned LN_HB_STRAP     = 5;

  // ----------------------------------------
  // software writable fields
  // ----------------------------------------
  localparam int unsigned FLD_W   = 5;
  localparam int unsigned FLD_BP  = 0;
  localparam int unsigned FLD_TX  = 1;
  localparam int unsigned FLD_RX  = 2;
  localparam int unsigned FLD_MAN = 3;
  localparam int unsigned FLD_HB  = 4;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic       RST_BIT        = 1'h0;
  localparam logic       MAC_MANUAL_DEF = 1'h1;
  localparam logic [1:0] SETTLE_CYCLES  = 2'h2;
  localparam logic [1:0] CNT_ONE        = 2'h1;
  localparam logic [1:0] CNT_ZERO       = 2'h0;

  typedef enum logic {ST_SETTLE, ST_RUN} psd_state_t;
endpackage

// ---- psd_port0_strap_defaults.sv ----
`timescale 1ns/100ps
`default_nettype none
module psd_port0_strap_defaults (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // board pins and straps
  input  wire logic                     duplex_pin_i,
  input  wire logic                     duplex_pol_strap_i,
  input  wire logic                     port0_backpressure_strap_i,
  input  wire logic                     port0_pause_enable_strap_i,
  input  wire logic                     port0_manual_flow_strap_i,
  input  wire logic                     heartbeat_disable_strap_i,
  // mode and negotiation
  input  wire logic                     mac_mode_i,
  input  wire logic                     vneg_enable_i,
  input  wire logic                     vneg_tx_pause_i,
  input  wire logic                     vneg_rx_pause_i,
  // software field writes
  input  wire logic [psd_pkg::FLD_W-1:0] sw_wr_i,
  input  wire logic [psd_pkg::FLD_W-1:0] sw_wdata_i,
  // settings out
  output logic                          defaults_loaded_o,
  output logic                          port0_full_duplex_o,
  output logic                          port0_backpressure_enable_o,
  output logic                          port0_tx_pause_enable_o,
  output logic                          port0_rx_pause_enable_o,
  output logic                          port0_manual_flow_select_o,
  output logic                          heartbeat_test_off_o,
  output logic                          port0_tx_pause_active_o,
  output logic                          port0_rx_pause_active_o
);
  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  psd_sync_if lanes ();
  logic [psd_pkg::SYNC_W-1:0] s;

  assign lanes.raw[psd_pkg::LN_DUPLEX_PIN]   = duplex_pin_i;
  assign lanes.raw[psd_pkg::LN_DUPLEX_POL]   = duplex_pol_strap_i;
  assign lanes.raw[psd_pkg::LN_BP_STRAP]     = port0_backpressure_strap_i;
  assign lanes.raw[psd_pkg::LN_PAUSE_STRAP]  = port0_pause_enable_strap_i;
  assign lanes.raw[psd_pkg::LN_MANUAL_STRAP] = port0_manual_flow_strap_i;
  assign lanes.raw[psd_pkg::LN_HB_STRAP]     = heartbeat_disable_strap_i;
  assign s = lanes.synced;

  psd_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .lanes   (lanes)
  );

  // ----------------------------------------
  // strap capture sequencer
  // ----------------------------------------
  psd_pkg::psd_state_t state_q;
  psd_pkg::psd_state_t state_d;
  logic [1:0]          cnt_q;
  logic [1:0]          cnt_d;
  logic                load_now;

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    load_now = 1'b0;
    unique case (state_q)
      psd_pkg::ST_SETTLE:
      begin
        if (cnt_q == psd_pkg::SETTLE_CYCLES)
        begin
          load_now = 1'b1;
          state_d  = psd_pkg::ST_RUN;
        end
        else
        begin
          cnt_d = cnt_q + psd_pkg::CNT_ONE;
        end
      end
      psd_pkg::ST_RUN:
      begin
        cnt_d = cnt_q;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= psd_pkg::ST_SETTLE;
      cnt_q   <= psd_pkg::CNT_ZERO;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------
  // setting registers
  // ----------------------------------------
  logic pol_q, pol_d;
  logic bp_q, bp_d;
  logic tx_q, tx_d;
  logic rx_q, rx_d;
  logic man_q, man_d;
  logic hb_q, hb_d;
  logic fd_q, fd_d;
  logic txa_q, txa_d;
  logic rxa_q, rxa_d;
  logic run;

  assign run = (state_q == psd_pkg::ST_RUN);

  always_comb
  begin
    pol_d = pol_q;
    bp_d  = bp_q;
    tx_d  = tx_q;
    rx_d  = rx_q;
    man_d = man_q;
    hb_d  = hb_q;
    if (load_now)
    begin
      pol_d = s[psd_pkg::LN_DUPLEX_POL];
      bp_d  = s[psd_pkg::LN_BP_STRAP];
      tx_d  = s[psd_pkg::LN_PAUSE_STRAP];
      rx_d  = s[psd_pkg::LN_PAUSE_STRAP];
      // mac mode: host drives flow control by hand
      man_d = mac_mode_i ? psd_pkg::MAC_MANUAL_DEF : s[psd_pkg::LN_MANUAL_STRAP];
      hb_d  = s[psd_pkg::LN_HB_STRAP];
    end
    else if (run)
    begin
      if (sw_wr_i[psd_pkg::FLD_BP])  bp_d  = sw_wdata_i[psd_pkg::FLD_BP];
      if (sw_wr_i[psd_pkg::FLD_TX])  tx_d  = sw_wdata_i[psd_pkg::FLD_TX];
      if (sw_wr_i[psd_pkg::FLD_RX])  rx_d  = sw_wdata_i[psd_pkg::FLD_RX];
      if (sw_wr_i[psd_pkg::FLD_MAN]) man_d = sw_wdata_i[psd_pkg::FLD_MAN];
      if (sw_wr_i[psd_pkg::FLD_HB])  hb_d  = sw_wdata_i[psd_pkg::FLD_HB];
    end
    fd_d = run && (s[psd_pkg::LN_DUPLEX_PIN] == pol_q);
    if (!run)
    begin
      txa_d = psd_pkg::RST_BIT;
      rxa_d = psd_pkg::RST_BIT;
    end
    else if (man_q)
    begin
      txa_d = tx_q;
      rxa_d = rx_q;
    end
    else
    begin
      txa_d = vneg_enable_i && vneg_tx_pause_i;
      rxa_d = vneg_enable_i && vneg_rx_pause_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pol_q <= psd_pkg::RST_BIT;
      bp_q  <= psd_pkg::RST_BIT;
      tx_q  <= psd_pkg::RST_BIT;
      rx_q  <= psd_pkg::RST_BIT;
      man_q <= psd_pkg::RST_BIT;
      hb_q  <= psd_pkg::RST_BIT;
      fd_q  <= psd_pkg::RST_BIT;
      txa_q <= psd_pkg::RST_BIT;
      rxa_q <= psd_pkg::RST_BIT;
    end
    else
    begin
      pol_q <= pol_d;
      bp_q  <= bp_d;
      tx_q  <= tx_d;
      rx_q  <= rx_d;
      man_q <= man_d;
      hb_q  <= hb_d;
      fd_q  <= fd_d;
      txa_q <= txa_d;
      rxa_q <= rxa_d;
    end
  end

  assign defaults_loaded_o           = run;
  assign port0_full_duplex_o         = fd_q;
  assign port0_backpressure_enable_o = bp_q;
  assign port0_tx_pause_enable_o     = tx_q;
  assign port0_rx_pause_enable_o     = rx_q;
  assign port0_manual_flow_select_o  = man_q;
  assign heartbeat_test_off_o        = hb_q;
  assign port0_tx_pause_active_o     = txa_q;
  assign port0_rx_pause_active_o     = rxa_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_duplex_match: assert property (@(posedge clk_i) disable iff (reset_i)
    (run && $stable(pol_q)) |=> (port0_full_duplex_o == ($past(s[psd_pkg::LN_DUPLEX_PIN]) == pol_q)))
    else $error("duplex select wrong");
  a_bp_default: assert property (@(posedge clk_i) disable iff (reset_i)
    load_now |=> (bp_q == $past(port0_backpressure_strap_i, 3)))
    else $error("backpressure default wrong");
  a_pause_default: assert property (@(posedge clk_i) disable iff (reset_i)
    load_now |=> (tx_q == $past(s[psd_pkg::LN_PAUSE_STRAP])) && (rx_q == tx_q))
    else $error("pause defaults wrong");
  a_negotiated_flow: assert property (@(posedge clk_i) disable iff (reset_i)
    (run && !man_q) |=> (txa_q == $past(vneg_enable_i && vneg_tx_pause_i))
      && (rxa_q == $past(vneg_enable_i && vneg_rx_pause_i)))
    else $error("negotiated flow control not applied");
  a_manual_flow: assert property (@(posedge clk_i) disable iff (reset_i)
    (run && man_q) |=> (txa_q == $past(tx_q)) && (rxa_q == $past(rx_q)))
    else $error("manual pause bits not applied");
  a_mac_ignores_strap: assert property (@(posedge clk_i) disable iff (reset_i)
    (load_now && mac_mode_i) |=> man_q)
    else $error("manual strap used in mac mode");
  a_heartbeat_default: assert property (@(posedge clk_i) disable iff (reset_i)
    load_now |=> (heartbeat_test_off_o == $past(s[psd_pkg::LN_HB_STRAP])))
    else $error("heartbeat default wrong");
  a_sw_override: assert property (@(posedge clk_i) disable iff (reset_i)
    (run && sw_wr_i[psd_pkg::FLD_BP]) ##1 !sw_wr_i[psd_pkg::FLD_BP]
      |-> (bp_q == $past(sw_wdata_i[psd_pkg::FLD_BP])) ##1 $stable(bp_q))
    else $error("software write lost");
  a_load_timing: assert property (@(posedge clk_i)
    $fell(reset_i) |-> !run ##1 !run ##1 load_now ##1 run)
    else $error("strap capture timing wrong");
endmodule // psd_port0_strap_defaults
`default_nettype wire

// ---- psd_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module psd_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // lanes
  psd_sync_if.sync_side lanes
);
  logic [psd_pkg::SYNC_W-1:0] meta_q;
  logic [psd_pkg::SYNC_W-1:0] meta_d;
  logic [psd_pkg::SYNC_W-1:0] stab_q;
  logic [psd_pkg::SYNC_W-1:0] stab_d;

  always_comb
  begin
    meta_d = lanes.raw;
    stab_d = meta_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      stab_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign lanes.synced = stab_q;
endmodule // psd_sync
`default_nettype wire

// ---- psd_sync_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface psd_sync_if;
  logic [psd_pkg::SYNC_W-1:0] raw;
  logic [psd_pkg::SYNC_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [4:0] PATS [4] = '{5'h00, 5'h1f, 5'h0a, 5'h15};
  logic       clk_i   = 1'h0;
  logic       reset_i = 1'h1;
  logic [4:0] straps  = 5'h00;
  logic       pin     = 1'h0;
  logic       mac     = 1'h0;
  logic       ven     = 1'h0;
  logic [1:0] vp      = 2'h0;
  logic [4:0] wr      = 5'h00;
  logic [4:0] wd      = 5'h00;
  logic       bp_s, pause_s, man_s, hb_s, pol_s;
  logic       loaded, fdx, bp, txe, rxe, man, hb, txa, rxa;
  int         failures = 0;
  int         checks   = 0;

  // ------------
  // clock, board, design
  // ------------
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  psd_board_model board (.pattern_i(straps), .bp_o(bp_s), .pause_o(pause_s),
    .manual_o(man_s), .hb_o(hb_s), .pol_o(pol_s));

  psd_port0_strap_defaults uut (.clk_i(clk_i), .reset_i(reset_i), .duplex_pin_i(pin),
    .duplex_pol_strap_i(pol_s), .port0_backpressure_strap_i(bp_s),
    .port0_pause_enable_strap_i(pause_s), .port0_manual_flow_strap_i(man_s),
    .heartbeat_disable_strap_i(hb_s), .mac_mode_i(mac), .vneg_enable_i(ven),
    .vneg_tx_pause_i(vp[0]), .vneg_rx_pause_i(vp[1]), .sw_wr_i(wr), .sw_wdata_i(wd),
    .defaults_loaded_o(loaded), .port0_full_duplex_o(fdx),
    .port0_backpressure_enable_o(bp), .port0_tx_pause_enable_o(txe),
    .port0_rx_pause_enable_o(rxe), .port0_manual_flow_select_o(man),
    .heartbeat_test_off_o(hb), .port0_tx_pause_active_o(txa),
    .port0_rx_pause_active_o(rxa));

  // ------------
  // tasks
  // ------------
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset(input logic [4:0] s, input logic p, input logic m);
    @(posedge clk_i);
    reset_i <= 1'h1;
    straps  <= s;
    pin     <= p;
    mac     <= m;
    tick(20);
    check(loaded, 1'h0, "loaded in reset");
    @(posedge clk_i);
    reset_i <= 1'h0;
    for (int i = 0; i < 10 && loaded !== 1'h1; i++)
      tick(1);
    if (loaded !== 1'h1)
    begin
      failures++;
      $display("Error %0t: load timeout", $time);
      close_out();
    end
    // duplex output settles one edge after the load
    tick(1);
  endtask

  task automatic sw_write(input logic [4:0] mask, input logic [4:0] data);
    @(posedge clk_i);
    wr <= mask;
    wd <= data;
    @(posedge clk_i);
    wr <= 5'h00;
    #1;
  endtask

  task automatic defaults(input logic [4:0] s, input logic p, input logic m);
    check(bp, s[0], "backpressure");
    check(txe, s[1], "tx pause");
    check(rxe, s[1], "rx pause");
    check(man, m | s[2], "manual select");
    check(hb, s[3], "heartbeat off");
    check(fdx, p == s[4], "duplex");
  endtask

  // ------------
  // tests
  // ------------
  initial
  begin
    for (int k = 0; k < 4; k++)
    begin
      do_reset(PATS[k], PATS[k][1], 1'h0);
      defaults(PATS[k], PATS[k][1], 1'h0);
    end
    @(posedge clk_i);
    pin <= 1'h1;
    tick(4);
    check(fdx, 1'h1, "live duplex");
    $display("test strap defaults done");

    do_reset(5'h03, 1'h0, 1'h0);
    @(posedge clk_i);
    ven <= 1'h1;
    vp  <= 2'h1;
    tick(2);
    check(txa, 1'h1, "neg tx");
    check(rxa, 1'h0, "neg rx");
    @(posedge clk_i);
    vp <= 2'h2;
    tick(2);
    check(txa, 1'h0, "neg tx");
    check(rxa, 1'h1, "neg rx");
    @(posedge clk_i);
    ven <= 1'h0;
    tick(2);
    check(rxa, 1'h0, "neg off");
    @(posedge clk_i);
    ven <= 1'h1;
    vp  <= 2'h0;
    sw_write(5'h08, 5'h08);
    tick(1);
    check(txa, 1'h1, "manual tx");
    check(rxa, 1'h1, "manual rx");
    sw_write(5'h1f, 5'h10);
    defaults(5'h08, 1'h0, 1'h0);
    $display("test flow select done");

    do_reset(5'h02, 1'h0, 1'h1);
    check(man, 1'h1, "mac manual");
    sw_write(5'h06, 5'h02);
    tick(1);
    check(txa, 1'h1, "host tx");
    check(rxa, 1'h0, "host rx");
    $display("test mac mode done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
